//--- src/ssq_map.svh
// Register offsets, field positions, reset values and timing counts of the step sequencer
`ifndef SSQ_MAP_SVH
`define SSQ_MAP_SVH

`define SSQ_CTRL_OFS 12'h000
`define SSQ_STATUS_OFS 12'h004
`define SSQ_POS_OFS 12'h008
`define SSQ_STEPCNT_OFS 12'h00c

`define SSQ_CTRL_TRIP_BIT 0
`define SSQ_CTRL_CNTEN_BIT 1
`define SSQ_CTRL_RST 2'h2

`define SSQ_ST_OUTEN_BIT 0
`define SSQ_ST_PROT_BIT 1
`define SSQ_ST_MON_BIT 2
`define SSQ_ST_LSLEEP_BIT 3
`define SSQ_ST_DSTBY_BIT 4
`define SSQ_ST_WAKE_BIT 5
`define SSQ_ST_SYNC_BIT 6
`define SSQ_ST_PWR_LSB 8

`define SSQ_POS_POS_LSB 0
`define SSQ_POS_MODE_LSB 8
`define SSQ_POS_ANEG_BIT 12
`define SSQ_POS_ALVL_LSB 16
`define SSQ_POS_BNEG_BIT 20
`define SSQ_POS_BLVL_LSB 24

`define SSQ_POS_RST 6'h00
`define SSQ_STEPCNT_RST 16'h0000
`define SSQ_LVL_MODE8 4'h8
`define SSQ_LVL_MODEF 4'hf

`define SSQ_CLK_MHZ 100
`define SSQ_STEP_MIN_US 2
`define SSQ_STEP_MIN_CYC (`SSQ_STEP_MIN_US * `SSQ_CLK_MHZ)
`define SSQ_RST_MIN_US 2
`define SSQ_RST_MIN_CYC (`SSQ_RST_MIN_US * `SSQ_CLK_MHZ)
`define SSQ_RST_TO_STEP_US 5
`define SSQ_RST_TO_STEP_CYC (`SSQ_RST_TO_STEP_US * `SSQ_CLK_MHZ + 1)
`define SSQ_WAKE_US 100
`define SSQ_WAKE_CYC (`SSQ_WAKE_US * `SSQ_CLK_MHZ)

`endif

//--- src/ssq_pkg.sv
// Types of the step sequencer
`default_nettype none
package ssq_pkg;

  typedef enum logic [1:0] {
    ssq_active = 2'h0,
    ssq_lsleep = 2'h1,
    ssq_dstby = 2'h3,
    ssq_prot = 2'h2
  } ssq_pwr_t;

  typedef enum logic [2:0] {
    ssq_full8 = 3'h0,
    ssq_fullf = 3'h1,
    ssq_half = 3'h2,
    ssq_halff = 3'h3,
    ssq_quarter = 3'h4,
    ssq_eighth = 3'h5,
    ssq_sixteenth = 3'h6,
    ssq_hold = 3'h7
  } ssq_res_t;

endpackage : ssq_pkg
`default_nettype wire

//--- src/ssq_sync.sv
// Two-flop synchroniser for a group of pin levels
`default_nettype none
module ssq_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ssq_sync
`default_nettype wire

//--- src/ssq_stepper_seq.sv
// Step sequencer with sleep, standby, protection latch and APB registers
//
// Contract
// [RULE1] Reset pin asynchronously clears sequencer state
// [RULE2] After reset, outputs on at initial position
// [RULE3] Reset pin never disables outputs
// [RULE4] Direction low forward, high reverse
// [RULE5] Sleep input high disables outputs, logic runs
// [RULE6] Steps still advance during light sleep
// [RULE7] Deep standby disables outputs, ignores steps
// [RULE8] Full/half mode pin decode, sel2 standby
// [RULE9] Microstep decode quarter eighth sixteenth, HHH standby
// [RULE10] Sync chopping only at 2-phase positions
// [RULE11] 2-phase means both levels Mode 8/F
// [RULE12] Monitor high only at 2-phase timing
// [RULE13] Protection trip latches outputs off, flag high
// [RULE14] Rising edge, or both edges on dual
// [RULE15] Host holds step phases at least 2 us
// [RULE16] Host waits 100 us after wake
// [RULE17] Host holds reset at least 2 us
// [RULE18] Host waits over 5 us reset-to-step
// [RULE19] Direction and mode apply at step edge
// [RULE20] Each step moves one resolution unit; code masks an off-grid result to the new grid, so that step differs
`include "ssq_map.svh"
`default_nettype none
module ssq_stepper_seq #(
  parameter bit MICROSTEP = 1'b1,
  parameter bit DUAL_EDGE = 1'b0,
  parameter int unsigned WAKE_CYC = `SSQ_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_pulse,
  input wire logic direction_select,
  input wire logic step_mode_sel0,
  input wire logic step_mode_sel1,
  input wire logic step_mode_sel2,
  input wire logic reference_sleep_input,
  input wire logic sync_select,
  input wire logic motor_reset,
  input wire logic fault_trip,
  output logic outputs_enable,
  output logic phase_a_negative,
  output logic [3:0] phase_a_level,
  output logic phase_b_negative,
  output logic [3:0] phase_b_level,
  output logic full_step_monitor,
  output logic protection_flag,
  output logic sync_chop_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] pins_raw;
  logic [7:0] pins_s;
  logic step_s;
  logic dir_s;
  logic [2:0] code_s;
  logic sleep_s;
  logic sync_s;
  logic fault_s;

  assign pins_raw = {fault_trip, sync_select, reference_sleep_input, step_mode_sel2,
                     step_mode_sel1, step_mode_sel0, direction_select, step_pulse};

  ssq_sync #(.W(8)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign step_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign code_s = pins_s[4:2];
  assign sleep_s = pins_s[5];
  assign sync_s = pins_s[6];
  assign fault_s = pins_s[7];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer reset: asserted at once, released through two flops

  wire seq_rst_raw_n = presetn & ~motor_reset;
  logic seq_meta_r;
  logic seq_rst_n;

  always_ff @(posedge pclk or negedge seq_rst_raw_n) begin
    if (!seq_rst_raw_n) begin // see [RULE1]
      seq_meta_r <= 1'b0;
      seq_rst_n <= 1'b0;
    end else begin
      seq_meta_r <= 1'b1;
      seq_rst_n <= seq_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and step edge

  ssq_pkg::ssq_res_t res_pin;
  ssq_pkg::ssq_res_t mode_r;
  logic step_d_r;
  wire step_rise = step_s & ~step_d_r;
  wire step_fall = ~step_s & step_d_r;
  wire step_edge = step_rise | (DUAL_EDGE & step_fall); // see [RULE14]

  // Full/half parts treat every sel2-high code as standby
  assign res_pin = (!MICROSTEP && code_s[2]) ? ssq_pkg::ssq_hold : // see [RULE8]
                   ssq_pkg::ssq_res_t'(code_s); // see [RULE9]

  wire deep_live = (res_pin == ssq_pkg::ssq_hold); // see [RULE7]
  wire step_take = step_edge & ~deep_live; // see [RULE6] [RULE7]

  logic [5:0] step_size;

  always_comb begin
    case (res_pin)
      ssq_pkg::ssq_full8, ssq_pkg::ssq_fullf: step_size = 6'h10;
      ssq_pkg::ssq_half, ssq_pkg::ssq_halff: step_size = 6'h08;
      ssq_pkg::ssq_quarter: step_size = 6'h04;
      ssq_pkg::ssq_eighth: step_size = 6'h02;
      ssq_pkg::ssq_sixteenth: step_size = 6'h01;
      default: step_size = 6'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position: 64 sixteenth-step slots, slot 0 is the initial excitation

  logic [5:0] pos_r;
  logic [5:0] pos_nxt;
  wire [5:0] pos_moved = dir_s ? 6'(pos_r + step_size) : 6'(pos_r - step_size); // see [RULE4]
  // Snap to the new resolution grid when the mode changes off-grid
  wire [5:0] pos_mask = ~6'(step_size - 6'h01);

  assign pos_nxt = step_take ? (pos_moved & pos_mask) : pos_r; // see [RULE20]

  always_ff @(posedge pclk or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      pos_r <= `SSQ_POS_RST; // see [RULE1] [RULE2]
      mode_r <= ssq_pkg::ssq_full8;
      step_d_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      step_d_r <= step_s;
      if (step_take) begin
        mode_r <= res_pin; // see [RULE19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase polarity and current-ratio levels

  wire [5:0] q_a = 6'(pos_r + 6'h08);
  wire [5:0] q_b = 6'(pos_r + 6'h18);
  wire [4:0] r_a = q_a[4:0];
  wire [4:0] r_b = q_b[4:0];
  wire [4:0] d_a = (r_a <= 5'h10) ? r_a : 5'(6'h20 - {1'b0, r_a});
  wire [4:0] d_b = (r_b <= 5'h10) ? r_b : 5'(6'h20 - {1'b0, r_b});
  wire [3:0] lvl_a_raw = (d_a <= 5'h01) ? `SSQ_LVL_MODEF : 4'(5'h10 - d_a);
  wire [3:0] lvl_b_raw = (d_b <= 5'h01) ? `SSQ_LVL_MODEF : 4'(5'h10 - d_b);
  wire a_neg = (q_a > 6'h10) && (q_a < 6'h30);
  wire b_neg = (q_a > 6'h20);
  wire force_f = (mode_r == ssq_pkg::ssq_fullf) || (mode_r == ssq_pkg::ssq_halff);
  wire [3:0] lvl_a = (force_f && lvl_a_raw != 4'h0) ? `SSQ_LVL_MODEF : lvl_a_raw;
  wire [3:0] lvl_b = (force_f && lvl_b_raw != 4'h0) ? `SSQ_LVL_MODEF : lvl_b_raw;

  wire lvl_a_2ph = (lvl_a == `SSQ_LVL_MODE8) || (lvl_a == `SSQ_LVL_MODEF);
  wire lvl_b_2ph = (lvl_b == `SSQ_LVL_MODE8) || (lvl_b == `SSQ_LVL_MODEF);
  wire two_phase = lvl_a_2ph & lvl_b_2ph; // see [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [1:0] ctrl_r;
  logic [15:0] stepcnt_r;
  logic [31:0] rd_mux;
  logic prot_r;
  logic wake_ready_r;
  ssq_pkg::ssq_pwr_t pwr_r;
  ssq_pkg::ssq_pwr_t pwr_nxt;

  wire hit_ctrl = (paddr == `SSQ_CTRL_OFS);
  wire hit_status = (paddr == `SSQ_STATUS_OFS);
  wire hit_pos = (paddr == `SSQ_POS_OFS);
  wire hit_cnt = (paddr == `SSQ_STEPCNT_OFS);
  wire hit_any = hit_ctrl | hit_status | hit_pos | hit_cnt;
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_ctrl = access_ph & pwrite & hit_ctrl;
  wire wr_cnt = access_ph & pwrite & hit_cnt;
  wire trip_wr = wr_ctrl & pwdata[`SSQ_CTRL_TRIP_BIT];

  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;

  wire [31:0] status_word = (32'(outputs_enable) << `SSQ_ST_OUTEN_BIT)
                          | (32'(prot_r) << `SSQ_ST_PROT_BIT)
                          | (32'(full_step_monitor) << `SSQ_ST_MON_BIT)
                          | (32'(sleep_s) << `SSQ_ST_LSLEEP_BIT)
                          | (32'(deep_live) << `SSQ_ST_DSTBY_BIT)
                          | (32'(wake_ready_r) << `SSQ_ST_WAKE_BIT)
                          | (32'(sync_chop_active) << `SSQ_ST_SYNC_BIT)
                          | (32'(pwr_r) << `SSQ_ST_PWR_LSB);

  wire [31:0] pos_word = (32'(pos_r) << `SSQ_POS_POS_LSB)
                       | (32'(mode_r) << `SSQ_POS_MODE_LSB)
                       | (32'(a_neg) << `SSQ_POS_ANEG_BIT)
                       | (32'(lvl_a) << `SSQ_POS_ALVL_LSB)
                       | (32'(b_neg) << `SSQ_POS_BNEG_BIT)
                       | (32'(lvl_b) << `SSQ_POS_BLVL_LSB);

  assign rd_mux = hit_ctrl ? {30'h0, ctrl_r[1], 1'b0} :
                  hit_status ? status_word :
                  hit_pos ? pos_word :
                  hit_cnt ? {16'h0, stepcnt_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      ctrl_r <= `SSQ_CTRL_RST;
    end else begin
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_r <= {pwdata[`SSQ_CTRL_CNTEN_BIT], 1'b0};
      end
    end
  end

  // Step count: a counted step (count enable set) in the clearing cycle wins and the clear is lost
  wire cnt_inc = step_take & ctrl_r[1];
  wire [15:0] stepcnt_nxt = cnt_inc ? 16'(stepcnt_r + 16'h0001) :
                            wr_cnt ? `SSQ_STEPCNT_RST : stepcnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stepcnt_r <= `SSQ_STEPCNT_RST;
    end else begin
      stepcnt_r <= stepcnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state and protection latch

  // Cleared only by power-on reset, never by the motor reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= 1'b0;
    end else if (fault_s | trip_wr) begin
      prot_r <= 1'b1; // see [RULE13]
    end
  end

  always_comb begin
    case (pwr_r)
      ssq_pkg::ssq_prot: pwr_nxt = ssq_pkg::ssq_prot;
      default: begin
        if (prot_r) begin
          pwr_nxt = ssq_pkg::ssq_prot; // see [RULE13]
        end else if (deep_live) begin
          pwr_nxt = ssq_pkg::ssq_dstby; // see [RULE7]
        end else if (sleep_s) begin
          pwr_nxt = ssq_pkg::ssq_lsleep; // see [RULE5]
        end else begin
          pwr_nxt = ssq_pkg::ssq_active; // see [RULE2] [RULE3]
        end
      end
    endcase
  end

  // Wake timer: reports when the first step after wake is safe
  logic [15:0] wake_cnt_r;
  wire awake = (pwr_r == ssq_pkg::ssq_active);
  wire wake_done = (wake_cnt_r >= 16'(WAKE_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= ssq_pkg::ssq_active;
      wake_cnt_r <= 16'h0000;
      wake_ready_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      if (!awake) begin
        wake_cnt_r <= 16'h0000;
      end else if (!wake_done) begin
        wake_cnt_r <= 16'(wake_cnt_r + 16'h0001);
      end
      wake_ready_r <= awake & wake_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  wire out_on = (pwr_nxt == ssq_pkg::ssq_active); // see [RULE3] [RULE5] [RULE7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outputs_enable <= 1'b0;
      phase_a_negative <= 1'b0;
      phase_a_level <= `SSQ_LVL_MODE8;
      phase_b_negative <= 1'b0;
      phase_b_level <= `SSQ_LVL_MODE8;
      full_step_monitor <= MICROSTEP; // see [RULE12]
      protection_flag <= 1'b0;
      sync_chop_active <= 1'b0;
    end else begin
      outputs_enable <= out_on;
      phase_a_negative <= a_neg;
      phase_a_level <= lvl_a;
      phase_b_negative <= b_neg;
      phase_b_level <= lvl_b;
      full_step_monitor <= MICROSTEP & two_phase; // see [RULE12]
      protection_flag <= prot_r; // see [RULE13]
      sync_chop_active <= sync_s & two_phase & out_on; // see [RULE10]
    end
  end

endmodule : ssq_stepper_seq
`default_nettype wire

//--- tb/ssq_checker.sv
// Port assertions of the step sequencer
`default_nettype none
module ssq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic step_pulse,
  input wire logic reference_sleep_input,
  input wire logic motor_reset,
  input wire logic fault_trip,
  input wire logic step_mode_sel2,
  input wire logic outputs_enable,
  input wire logic [3:0] phase_a_level,
  input wire logic [3:0] phase_b_level,
  input wire logic full_step_monitor,
  input wire logic protection_flag,
  input wire logic sync_chop_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_err; psel && penable && paddr > 12'h00c |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_err_acc; pslverr |-> psel && penable; endproperty
  a_err_acc: assert property (p_err_acc) else $error("error outside access");
  property p_lat; protection_flag |=> protection_flag; endproperty
  a_lat: assert property (p_lat) else $error("flag dropped");
  property p_prot; protection_flag |-> !outputs_enable; endproperty
  a_prot: assert property (p_prot) else $error("outputs on in fault");
  // Two sync flops, latch and output flop: flag shows one cycle after four trip samples
  property p_trip; fault_trip [*4] |=> protection_flag; endproperty
  a_trip: assert property (p_trip) else $error("trip not flagged");
  property p_sleep; reference_sleep_input [*4] |-> !outputs_enable; endproperty
  a_sleep: assert property (p_sleep) else $error("outputs on in sleep");
  property p_mon;
    full_step_monitor == (phase_a_level inside {4'h8, 4'hf} && phase_b_level inside {4'h8, 4'hf});
  endproperty
  a_mon: assert property (p_mon) else $error("monitor wrong");
  property p_sync; sync_chop_active |-> full_step_monitor && outputs_enable; endproperty
  a_sync: assert property (p_sync) else $error("sync off grid");
  property p_hold;
    (!motor_reset && $stable(step_pulse)) [*6] |-> $stable(phase_a_level) && $stable(phase_b_level);
  endproperty
  a_hold: assert property (p_hold) else $error("move without step");
  property p_mrst;
    motor_reset && outputs_enable && !reference_sleep_input && !step_mode_sel2 && !fault_trip
      |=> outputs_enable;
  endproperty
  a_mrst: assert property (p_mrst) else $error("reset disabled outputs");
endmodule : ssq_checker
bind ssq_stepper_seq ssq_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .step_pulse, .reference_sleep_input, .motor_reset, .fault_trip, .step_mode_sel2,
  .outputs_enable, .phase_a_level, .phase_b_level, .full_step_monitor, .protection_flag,
  .sync_chop_active);
`default_nettype wire

//--- tb/ssq_host.sv
// Host model issuing step pulses
`default_nettype none
module ssq_host #(
  parameter int HOLD = 200
) (
  input wire logic pclk,
  input wire logic go,
  output logic step_pulse,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial {step_pulse, busy} = 2'b00;
  always @(posedge pclk) begin
    if (busy) begin
      cnt <= cnt + 1;
      if (cnt == HOLD - 1) step_pulse <= 1'b0;
      if (cnt == 2 * HOLD - 1) busy <= 1'b0;
    end else if (go) begin
      busy <= 1'b1;
      step_pulse <= 1'b1;
      cnt <= 0;
    end
  end
endmodule : ssq_host
`default_nettype wire

//--- tb/stepper_step_sequencer_control_test.sv
// Self-checking bench of the step sequencer
`default_nettype none
module stepper_step_sequencer_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, step_pulse, busy, oe, an, bn, mon, flag, sca;
  logic go = 1'b0, dir = 1'b0, slp = 1'b0, syn = 1'b0, mrst = 1'b0, trip = 1'b0;
  logic [2:0] md = 3'h0;
  logic [3:0] al, bl;
  int failures = 0, n_compared = 0, cyc = 0;
  ssq_stepper_seq #(.WAKE_CYC(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .step_pulse, .direction_select(dir),
    .step_mode_sel0(md[0]), .step_mode_sel1(md[1]), .step_mode_sel2(md[2]),
    .reference_sleep_input(slp), .sync_select(syn), .motor_reset(mrst), .fault_trip(trip),
    .outputs_enable(oe), .phase_a_negative(an), .phase_a_level(al), .phase_b_negative(bn),
    .phase_b_level(bl), .full_step_monitor(mon), .protection_flag(flag),
    .sync_chop_active(sca));
  ssq_host u_host (.pclk, .go, .step_pulse, .busy);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      test_done;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task pos(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, 12'h008, 32'h0);
    chk(q & m, e);
  endtask : pos
  task step;
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
  endtask : step
  task ms(input logic [2:0] c, input logic [31:0] m, input logic [31:0] e);
    md <= c;
    dir <= 1'b1;
    repeat (100) @(posedge pclk);
    step;
    pos(m, e);
    // Phase pins must match the expected position word
    if (m[31]) begin
      chk({22'h0, an, al, bn, bl}, {22'h0, e[12], e[19:16], e[20], e[27:24]});
    end
  endtask : ms
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk({30'h0, oe, mon}, 32'h3);
    pos(32'hffffffff, 32'h08080000);
    apb(1'b0, 12'h010, 32'h0);
    chk({q[30:0], err}, 32'h1);
  endtask : t_reset
  task t_dir;
    repeat (100) @(posedge pclk);
    step;
    pos(32'h3f, 32'h30);
    dir <= 1'b1;
    repeat (300) @(posedge pclk);
    pos(32'h3f, 32'h30);
    step;
    pos(32'h3f, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h2);
  endtask : t_dir
  task t_modes;
    syn <= 1'b1;
    ms(3'h0, 32'hffffffff, 32'h08081010);
    ms(3'h1, 32'hffffffff, 32'h0f1f1120);
    ms(3'h3, 32'hffffffff, 32'h0f100328);
    chk({30'h0, mon, sca}, 32'h0);
    ms(3'h2, 32'hffffffff, 32'h08180230);
    chk({30'h0, mon, sca}, 32'h3);
    syn <= 1'b0;
    ms(3'h4, 32'h3f, 32'h34);
    ms(3'h6, 32'h3f, 32'h35);
    ms(3'h5, 32'h3f, 32'h36);
    ms(3'h7, 32'h3f, 32'h36);
    chk({31'h0, oe}, 32'h0);
  endtask : t_modes
  task t_mrst;
    md <= 3'h0;
    repeat (10000) @(posedge pclk);
    mrst <= 1'b1;
    repeat (200) @(posedge pclk);
    chk({31'h0, oe}, 32'h1);
    mrst <= 1'b0;
    repeat (501) @(posedge pclk);
    pos(32'h3f, 32'h0);
  endtask : t_mrst
  task t_sleep;
    slp <= 1'b1;
    repeat (100) @(posedge pclk);
    chk({31'h0, oe}, 32'h0);
    step;
    pos(32'h3f, 32'h10);
    slp <= 1'b0;
    repeat (10000) @(posedge pclk);
    chk({31'h0, oe}, 32'h1);
  endtask : t_sleep
  task t_fault;
    trip <= 1'b1;
    repeat (5) @(posedge pclk);
    trip <= 1'b0;
    repeat (100) @(posedge pclk);
    chk({30'h0, flag, oe}, 32'h2);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (501) @(posedge pclk);
    chk({30'h0, flag, oe}, 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    repeat (10) @(posedge pclk);
    chk({30'h0, flag, oe}, 32'h2);
  endtask : t_fault
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (501) @(posedge pclk);
    t_reset;
    t_dir;
    t_modes;
    t_mrst;
    t_sleep;
    t_fault;
    test_done;
  end
endmodule : stepper_step_sequencer_control_test
`default_nettype wire
